// file: include/opdec_map.svh
/*
 * Opcodes, reset values and widths for the interrupt control, watchdog
 * arm, power-down arm and port input execution logic.
 * Assumes a 10-bit instruction word from the fetch path.
 */
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH
`define OP_IRQ_DISABLE     10'h004
`define OP_IRQ_ENABLE      10'h005
`define OP_WDT_STOP_ARM    10'h29c
`define OP_PD_ARM          10'h05b
`define OP_PD              10'h002
`define OP_DEEP_PD         10'h008
`define OP_PORT_ZERO_RD    10'h260
`define OP_PORT_ONE_RD     10'h261
`define OP_PORT_TWO_RD     10'h262
`define OP_PORT_THREE_RD   10'h263
`define IRQ_EN_RST         1'b0
`define ACC_RST            4'h0
`define ARM_RST            1'b0
`define PULSE_RST          1'b0
`endif

// file: include/opdec_pkg.sv
/*
 * Types shared by the execution logic.
 * Assumes nothing of its surroundings.
 */
package opdec_pkg;
    typedef enum logic [2:0] {
        IRQ_IDLE    = 3'b001,
        IRQ_PEND_EN = 3'b010,
        IRQ_PEND_DI = 3'b100
    } irq_state_t;
endpackage : opdec_pkg

// file: hw/port_select.sv
/*
 * Selects one of four 4-bit input ports by index.
 * Assumes port levels are synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module port_select #(
    parameter int W = 4
) (
    input  wire logic [W-1:0] port_zero,
    input  wire logic [W-1:0] port_one,
    input  wire logic [W-1:0] port_two,
    input  wire logic [W-1:0] port_three,
    input  wire logic [1:0]   sel,
    output logic      [W-1:0] data
);
    always_comb begin
        case (sel)
            2'h0: data = port_zero;
            2'h1: data = port_one;
            2'h2: data = port_two;
            default: data = port_three;
        endcase
    end
endmodule : port_select
`default_nettype wire

// file: hw/opdec_exec.sv
/*
 * Execution logic for interrupt enable/disable, watchdog stop arming,
 * power-down validation and port 0..3 reads into the accumulator.
 * The watchdog stop itself, the power-down sequence and the interrupt
 * sources sit outside; this file only arms, pulses and flags them.
 * Opcodes that are not decoded here pass through with no effect.
 * Assumes one instruction per sys_clk edge when instr_valid is high, i.e.
 * sys_clk is the machine-cycle clock, and synchronous port levels.
 */
// Summary of operation
// - Disable op clears global interrupt enable flag.
// - Disable takes effect one machine cycle later.
// - Enable op sets global interrupt enable flag.
// - Enable takes effect one machine cycle later.
// - Watchdog stop arm op permits later watchdog stop.
// - Power-down arm validates the two power-down ops.
// - Port zero read loads accumulator, carry kept.
// - Port one read loads accumulator, carry kept.
// - Port two read loads accumulator, carry kept.
// - Port three read loads accumulator, carry kept.
`include "opdec_map.svh"
`timescale 1ns/1ps
`default_nettype none
module opdec_exec #(
    parameter int W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    input  wire logic         instr_valid,
    input  wire logic [9:0]   instr_word,
    input  wire logic [W-1:0] port_zero,
    input  wire logic [W-1:0] port_one,
    input  wire logic [W-1:0] port_two,
    input  wire logic [W-1:0] port_three,
    input  wire logic         wdt_stop_req,
    output logic              global_irq_enable_flag,
    output logic              wdt_stop_armed,
    output logic              wdt_stop,
    output logic              powerdown_armed,
    output logic              powerdown_go,
    output logic              deep_powerdown_go,
    output logic [W-1:0]      acc,
    output logic              acc_load,
    output logic              skip,
    output logic              carry_write
);
    localparam int NPORT = 4;
    // Read opcodes packed in port order, so a hit index is the port number.
    localparam logic [NPORT-1:0][9:0] PORT_RD_OP = {
        `OP_PORT_THREE_RD,
        `OP_PORT_TWO_RD,
        `OP_PORT_ONE_RD,
        `OP_PORT_ZERO_RD
    };

    opdec_pkg::irq_state_t irq_state_r;
    logic                  irq_en_r;
    logic                  wdt_arm_r;
    logic                  pd_arm_r;
    logic                  pd_go_r;
    logic                  dpd_go_r;
    logic [W-1:0]          acc_r;
    logic                  acc_load_r;

    logic [W-1:0]          port_data;
    logic [NPORT-1:0]      port_rd_hit;
    logic [1:0]            port_idx;
    logic                  is_di;
    logic                  is_ei;
    logic                  is_wdt_arm;
    logic                  is_pd_arm;
    logic                  is_pd;
    logic                  is_dpd;
    logic                  is_port_rd;

    // Every decode is gated by instr_valid, so a bubble never acts.
    assign is_di      = instr_valid
                        && (instr_word == `OP_IRQ_DISABLE);
    assign is_ei      = instr_valid
                        && (instr_word == `OP_IRQ_ENABLE);
    assign is_wdt_arm = instr_valid
                        && (instr_word == `OP_WDT_STOP_ARM);
    assign is_pd_arm  = instr_valid
                        && (instr_word == `OP_PD_ARM);
    assign is_pd      = instr_valid
                        && (instr_word == `OP_PD);
    assign is_dpd     = instr_valid
                        && (instr_word == `OP_DEEP_PD);

    generate
        for (genvar g = 0; g < NPORT; g++) begin : g_port_rd
            assign port_rd_hit[g] = instr_valid
                                    && (instr_word == PORT_RD_OP[g]);
        end
    endgenerate

    assign is_port_rd = |port_rd_hit;

    always_comb begin
        port_idx = 2'h0;
        if (port_rd_hit[1]) begin
            port_idx = 2'h1;
        end else if (port_rd_hit[2]) begin
            port_idx = 2'h2;
        end else if (port_rd_hit[3]) begin
            port_idx = 2'h3;
        end
    end

    port_select #(.W(W)) u_sel (
        .port_zero  (port_zero),
        .port_one   (port_one),
        .port_two   (port_two),
        .port_three (port_three),
        .sel        (port_idx),
        .data       (port_data)
    );

    // The new flag value lands one machine cycle after the instruction,
    // so the instruction following the change still runs unaffected.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_state_r <= opdec_pkg::IRQ_IDLE;
        end else if (is_ei) begin
            irq_state_r <= opdec_pkg::IRQ_PEND_EN;
        end else if (is_di) begin
            irq_state_r <= opdec_pkg::IRQ_PEND_DI;
        end else begin
            irq_state_r <= opdec_pkg::IRQ_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_en_r <= `IRQ_EN_RST;
        end else begin
            case (irq_state_r)
                opdec_pkg::IRQ_PEND_EN: begin
                    irq_en_r <= 1'b1;
                end
                opdec_pkg::IRQ_PEND_DI: begin
                    irq_en_r <= 1'b0;
                end
                opdec_pkg::IRQ_IDLE: begin
                    irq_en_r <= irq_en_r;
                end
                default: begin
                    irq_en_r <= irq_en_r;
                end
            endcase
        end
    end

    // Arming is sticky until reset; there is no instruction to disarm.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wdt_arm_r <= `ARM_RST;
        end else if (is_wdt_arm) begin
            wdt_arm_r <= 1'b1;
        end else begin
            wdt_arm_r <= wdt_arm_r;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pd_arm_r <= `ARM_RST;
        end else if (is_pd_arm) begin
            pd_arm_r <= 1'b1;
        end else begin
            pd_arm_r <= pd_arm_r;
        end
    end

    // A power-down op seen before arming is dropped, not kept for later.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pd_go_r <= `PULSE_RST;
        end else begin
            pd_go_r <= pd_arm_r && is_pd;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dpd_go_r <= `PULSE_RST;
        end else begin
            dpd_go_r <= pd_arm_r && is_dpd;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_load_r <= `PULSE_RST;
        end else begin
            acc_load_r <= is_port_rd;
        end
    end

    // The accumulator keeps its value between reads; carry is never written.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= `ACC_RST;
        end else if (is_port_rd) begin
            acc_r <= port_data;
        end else begin
            acc_r <= acc_r;
        end
    end

    assign global_irq_enable_flag = irq_en_r;
    assign wdt_stop_armed         = wdt_arm_r;
    assign wdt_stop               = wdt_arm_r && wdt_stop_req;
    assign powerdown_armed        = pd_arm_r;
    assign powerdown_go           = pd_go_r;
    assign deep_powerdown_go      = dpd_go_r;
    assign acc                    = acc_r;
    assign acc_load               = acc_load_r;
    assign skip                   = 1'b0;
    assign carry_write            = 1'b0;
endmodule : opdec_exec
`default_nettype wire

// file: verification/opdec_exec_monitor.sv
/* Port checker for opdec_exec.
   Assumes it is bound to opdec_exec and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "opdec_map.svh"
module opdec_exec_monitor #(parameter int W = 4) (
    input wire logic         sys_clk, sys_rst, instr_valid,
    input wire logic [9:0]   instr_word,
    input wire logic [W-1:0] port_zero, port_one, port_two, port_three,
    input wire logic         wdt_stop_req, global_irq_enable_flag,
    input wire logic         wdt_stop_armed, wdt_stop, powerdown_armed,
    input wire logic         powerdown_go, deep_powerdown_go, acc_load,
    input wire logic         skip, carry_write,
    input wire logic [W-1:0] acc
);
    logic [W-1:0] pin;
    assign pin = instr_word[1] ? (instr_word[0] ? port_three : port_two)
                               : (instr_word[0] ? port_one : port_zero);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_op(logic [9:0] c); instr_valid && instr_word == c; endsequence
    logic irq_op;
    assign irq_op = instr_valid && (instr_word == `OP_IRQ_ENABLE
                                    || instr_word == `OP_IRQ_DISABLE);
    property p_ei; s_op(`OP_IRQ_ENABLE) |-> ##2 global_irq_enable_flag;
    endproperty
    a_ei: assert property (p_ei) else $error("enable late");
    property p_di; s_op(`OP_IRQ_DISABLE) |-> ##2 !global_irq_enable_flag;
    endproperty
    a_di: assert property (p_di) else $error("disable late");
    // A flag change must trace back exactly two edges, not one.
    property p_dly; $changed(global_irq_enable_flag) |-> $past(irq_op, 2);
    endproperty
    a_dly: assert property (p_dly) else $error("flag early");
    property p_rd; instr_valid && instr_word[9:2] == 8'h98
        |=> acc_load && acc == $past(pin); endproperty
    a_rd: assert property (p_rd) else $error("port read");
    property p_nsk; !skip && !carry_write; endproperty
    a_nsk: assert property (p_nsk) else $error("skip or carry");
    property p_pd; s_op(`OP_PD) ##0 powerdown_armed |=> powerdown_go;
    endproperty
    a_pd: assert property (p_pd) else $error("pd lost");
    property p_dpd; s_op(`OP_DEEP_PD) ##0 powerdown_armed
        |=> deep_powerdown_go; endproperty
    a_dpd: assert property (p_dpd) else $error("deep pd lost");
    property p_pdq; powerdown_go |-> $past(powerdown_armed); endproperty
    a_pdq: assert property (p_pdq) else $error("pd unarmed");
    property p_wd; s_op(`OP_WDT_STOP_ARM) |=> wdt_stop_armed; endproperty
    a_wd: assert property (p_wd) else $error("wdt arm");
endmodule : opdec_exec_monitor
bind opdec_exec opdec_exec_monitor #(.W(W)) chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .port_zero(port_zero), .port_one(port_one),
    .port_two(port_two), .port_three(port_three),
    .wdt_stop_req(wdt_stop_req),
    .global_irq_enable_flag(global_irq_enable_flag),
    .wdt_stop_armed(wdt_stop_armed), .wdt_stop(wdt_stop),
    .powerdown_armed(powerdown_armed), .powerdown_go(powerdown_go),
    .deep_powerdown_go(deep_powerdown_go), .acc_load(acc_load),
    .skip(skip), .carry_write(carry_write), .acc(acc)
);
`default_nettype wire

// file: verification/opdec_exec_tb_top.sv
/* Random bench for opdec_exec against an integer model.
   Assumes the opcode map header and a 5 ns machine cycle. */
`timescale 1ns/1ps
`default_nettype none
`include "opdec_map.svh"
module opdec_exec_tb_top;
    logic sys_clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0;
    logic [9:0] instr_word = 10'h000;
    logic [3:0] port_zero = 4'h0, port_one = 4'h0;
    logic [3:0] port_two = 4'h0, port_three = 4'h0, acc;
    logic wdt_stop_req = 1'b0, global_irq_enable_flag, wdt_stop_armed;
    logic wdt_stop, powerdown_armed, powerdown_go, deep_powerdown_go;
    logic acc_load, skip, carry_write;
    logic [9:0] tbl[10] = '{`OP_IRQ_DISABLE, `OP_IRQ_ENABLE, `OP_PD,
        `OP_WDT_STOP_ARM, `OP_PD_ARM, `OP_DEEP_PD, `OP_PORT_ZERO_RD,
        `OP_PORT_ONE_RD, `OP_PORT_TWO_RD, `OP_PORT_THREE_RD};
    int err_count = 0, check_count = 0, ef, d1, ea, ewa, epa;
    bit v, el, epg, edg;
    always #2.5 sys_clk = ~sys_clk;
    opdec_exec dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .port_zero(port_zero),
        .port_one(port_one), .port_two(port_two), .port_three(port_three),
        .wdt_stop_req(wdt_stop_req),
        .global_irq_enable_flag(global_irq_enable_flag),
        .wdt_stop_armed(wdt_stop_armed), .wdt_stop(wdt_stop),
        .powerdown_armed(powerdown_armed), .powerdown_go(powerdown_go),
        .deep_powerdown_go(deep_powerdown_go), .acc(acc),
        .acc_load(acc_load), .skip(skip), .carry_write(carry_write)
    );
    task automatic chk(string n, logic [3:0] s, int e);
        check_count++;
        if (s !== 4'(e)) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", n, 4'(e), s);
        end
    endtask : chk
    task automatic model_reset();
        ef = 0;
        ea = 0;
        ewa = 0;
        epa = 0;
        d1 = -1;
    endtask : model_reset
    task automatic step();
        v = instr_valid;
        // The flag follows the op taken one machine cycle earlier.
        if (d1 >= 0) ef = d1;
        d1 = !v ? -1 : instr_word == `OP_IRQ_DISABLE ? 0
            : instr_word == `OP_IRQ_ENABLE ? 1 : -1;
        el = v && instr_word[9:2] == 8'h98;
        if (el) ea = instr_word[1] ? (instr_word[0] ? port_three : port_two)
            : (instr_word[0] ? port_one : port_zero);
        epg = v && instr_word == `OP_PD && epa;
        edg = v && instr_word == `OP_DEEP_PD && epa;
        if (v && instr_word == `OP_PD_ARM) epa = 1;
        if (v && instr_word == `OP_WDT_STOP_ARM) ewa = 1;
        chk("irq", global_irq_enable_flag, ef);
        chk("acc", acc, ea);
        chk("load", acc_load, el);
        chk("pd", powerdown_go, epg);
        chk("dpd", deep_powerdown_go, edg);
        chk("pda", powerdown_armed, epa);
        chk("wda", wdt_stop_armed, ewa);
        chk("wds", wdt_stop, ewa & wdt_stop_req);
        chk("skc", {skip, carry_write}, 0);
    endtask : step
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(89165));
        model_reset();
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 800; i++) begin
            @(negedge sys_clk);
            step();
            // A mid-run reset must drop both arms again.
            sys_rst = (i == 400);
            if (sys_rst) model_reset();
            instr_valid = !sys_rst && ($urandom % 4) != 0;
            instr_word = ($urandom % 6 == 0) ? 10'($urandom)
                : tbl[$urandom % 10];
            {port_zero, port_one, port_two, port_three} = 16'($urandom);
            wdt_stop_req = 1'($urandom);
        end
        finish_test();
    end
endmodule : opdec_exec_tb_top
`default_nettype wire
